//--- acp_pkg.sv
/*
  Constants shared by the card host port: state codes, pin reset values and cycle counts.
  Assumes a single 250 MHz clock domain.
*/
package acp_pkg;

  // ===========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned SETUP_TIME_NS   = 30;
  localparam int unsigned STROBE_TIME_NS  = 70;
  localparam int unsigned RESET_TIME_NS   = 400;
  localparam logic [7:0]  SETUP_CYCLES    = 8'((SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  STROBE_CYCLES   = 8'((STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  RESET_CYCLES    = 8'((RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ===========================================================================
  // Reset values of pin outputs
  localparam logic        PIN_IDLE        = 1'b1;
  localparam logic [2:0]  ADDR_RESET      = 3'h0;
  localparam logic [15:0] DATA_RESET      = 16'h0000;

  // ===========================================================================
  // Access sequencer
  typedef enum logic [2:0] {
    ACP_IDLE   = 3'b000,
    ACP_SETUP  = 3'b001,
    ACP_STROBE = 3'b010,
    ACP_WAIT   = 3'b011,
    ACP_DONE   = 3'b100,
    ACP_RESET  = 3'b101
  } acp_state_e;

endpackage

//--- acp_host_port.sv
/*
  Pin logic toward a removable storage card in native ATA mode: selects, register
  address, strobes, 16-bit data with byte-wide task-file accesses, reset, detect.
  Assumes pin inputs are already synchronous to clk_i; the pad ring resolves the
  data bus from the output enable (low = driving).
*/
`timescale 1ns/1ps

module acp_host_port
  import acp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        req_i,
  input  wire logic        req_write_i,
  input  wire logic        req_data_i,
  input  wire logic        req_alt_i,
  input  wire logic [2:0]  req_addr_i,
  input  wire logic [15:0] req_wdata_i,
  input  wire logic        reset_card_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [15:0]      rdata_o,
  output logic             intr_pending_o,
  output logic             card_inserted_o,
  output logic             ata_select_b_n_o,
  output logic             taskfile_select_n_o,
  output logic             reg_addr_bit2_o,
  output logic             reg_addr_bit1_o,
  output logic             reg_addr_bit0_o,
  output logic             card_read_strobe_n_o,
  output logic             card_write_strobe_n_o,
  output logic             card_reset_n_o,
  input  wire logic [15:0] card_data_i,
  output logic [15:0]      card_data_o,
  output logic             card_data_oe_n_o,
  input  wire logic        card_intr_req_i,
  input  wire logic        card_io_ready_i,
  input  wire logic        card_present_a_n_i,
  input  wire logic        card_present_b_n_i
);

  // ===========================================================================
  // State
  acp_state_e  state_r,    state_nxt;
  logic [7:0]  cnt_r,      cnt_nxt;
  logic        write_r,    write_nxt;
  logic        data_r,     data_nxt;
  logic        cs0_n_r,    cs0_n_nxt;
  logic        cs1_n_r,    cs1_n_nxt;
  logic [2:0]  addr_r,     addr_nxt;
  logic        rd_n_r,     rd_n_nxt;
  logic        wr_n_r,     wr_n_nxt;
  logic        rst_n_r,    rst_n_nxt;
  logic [15:0] dout_r,     dout_nxt;
  logic        oe_n_r,     oe_n_nxt;
  logic [15:0] rdata_r,    rdata_nxt;
  logic        done_r,     done_nxt;
  logic        intr_r,     intr_nxt;
  logic        present_r,  present_nxt;
  logic        busy_r,     busy_nxt;
  logic        present;
  // Byte-wide task-file accesses see only the low lane; the high byte reads zero
  function automatic logic [15:0] lane_mask(input logic full, input logic [15:0] v);
    lane_mask = full ? v : {8'h00, v[7:0]};
  endfunction

  // ===========================================================================
  // Next state
  always_comb begin
    present     = ~card_present_a_n_i & ~card_present_b_n_i;
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    write_nxt   = write_r;
    data_nxt    = data_r;
    cs0_n_nxt   = cs0_n_r;
    cs1_n_nxt   = cs1_n_r;
    addr_nxt    = addr_r;
    rd_n_nxt    = rd_n_r;
    wr_n_nxt    = wr_n_r;
    rst_n_nxt   = rst_n_r;
    dout_nxt    = dout_r;
    oe_n_nxt    = oe_n_r;
    rdata_nxt   = rdata_r;
    done_nxt    = 1'b0;
    intr_nxt    = card_intr_req_i & present;
    present_nxt = present;
    case (state_r)
      ACP_IDLE: begin
        cs0_n_nxt = PIN_IDLE;
        cs1_n_nxt = PIN_IDLE;
        oe_n_nxt  = PIN_IDLE;
        rst_n_nxt = PIN_IDLE;
        if (!present) begin  // No card: nothing starts, outputs rest
        end else if (reset_card_i) begin
          rst_n_nxt = 1'b0;
          cnt_nxt   = RESET_CYCLES;
          state_nxt = ACP_RESET;
        end else if (req_i) begin
          write_nxt = req_write_i;
          data_nxt  = req_data_i;
          addr_nxt  = req_addr_i;
          cs0_n_nxt = req_alt_i;
          cs1_n_nxt = ~req_alt_i;
          dout_nxt  = lane_mask(req_data_i, req_wdata_i);
          oe_n_nxt  = ~req_write_i;
          cnt_nxt   = SETUP_CYCLES;
          state_nxt = ACP_SETUP;
        end
      end
      ACP_SETUP: begin
        if (cnt_r > 8'h01) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          rd_n_nxt  = write_r;
          wr_n_nxt  = ~write_r;
          cnt_nxt   = STROBE_CYCLES;
          state_nxt = ACP_STROBE;
        end
      end
      ACP_STROBE: begin
        if (cnt_r > 8'h01) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          state_nxt = ACP_WAIT;
        end
      end
      ACP_WAIT: begin
        // Strobe is held for as long as the card holds ready low
        if (card_io_ready_i) begin
          if (!write_r) begin
            rdata_nxt = lane_mask(data_r, card_data_i);
          end
          rd_n_nxt  = PIN_IDLE;
          wr_n_nxt  = PIN_IDLE;
          state_nxt = ACP_DONE;
        end
      end
      ACP_DONE: begin
        cs0_n_nxt = PIN_IDLE;
        cs1_n_nxt = PIN_IDLE;
        oe_n_nxt  = PIN_IDLE;
        done_nxt  = 1'b1;
        state_nxt = ACP_IDLE;
      end
      ACP_RESET: begin
        if (cnt_r > 8'h01) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          rst_n_nxt = PIN_IDLE;
          done_nxt  = 1'b1;
          state_nxt = ACP_IDLE;
        end
      end
      default: begin
        state_nxt = ACP_IDLE;
      end
    endcase
    // Removal mid-cycle aborts at once; a stranded strobe could corrupt the next card
    if (!present && state_r != ACP_IDLE) begin
      state_nxt = ACP_IDLE;
      cs0_n_nxt = PIN_IDLE;
      cs1_n_nxt = PIN_IDLE;
      rd_n_nxt  = PIN_IDLE;
      wr_n_nxt  = PIN_IDLE;
      rst_n_nxt = PIN_IDLE;
      oe_n_nxt  = PIN_IDLE;
      done_nxt  = 1'b0;
    end
    busy_nxt = (state_nxt != ACP_IDLE);
  end

  // ===========================================================================
  // Registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r   <= ACP_IDLE;
      cnt_r     <= 8'h00;
      write_r   <= 1'b0;
      data_r    <= 1'b0;
      cs0_n_r   <= PIN_IDLE;
      cs1_n_r   <= PIN_IDLE;
      addr_r    <= ADDR_RESET;
      rd_n_r    <= PIN_IDLE;
      wr_n_r    <= PIN_IDLE;
      rst_n_r   <= PIN_IDLE;
      dout_r    <= DATA_RESET;
      oe_n_r    <= PIN_IDLE;
      rdata_r   <= DATA_RESET;
      done_r    <= 1'b0;
      intr_r    <= 1'b0;
      present_r <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      write_r   <= write_nxt;
      data_r    <= data_nxt;
      cs0_n_r   <= cs0_n_nxt;
      cs1_n_r   <= cs1_n_nxt;
      addr_r    <= addr_nxt;
      rd_n_r    <= rd_n_nxt;
      wr_n_r    <= wr_n_nxt;
      rst_n_r   <= rst_n_nxt;
      dout_r    <= dout_nxt;
      oe_n_r    <= oe_n_nxt;
      rdata_r   <= rdata_nxt;
      done_r    <= done_nxt;
      intr_r    <= intr_nxt;
      present_r <= present_nxt;
      busy_r    <= busy_nxt;
    end
  end

  assign busy_o                = busy_r;
  assign done_o                = done_r;
  assign rdata_o               = rdata_r;
  assign intr_pending_o        = intr_r;
  assign card_inserted_o       = present_r;
  assign ata_select_b_n_o      = cs1_n_r;
  assign taskfile_select_n_o   = cs0_n_r;
  assign reg_addr_bit2_o       = addr_r[2];
  assign reg_addr_bit1_o       = addr_r[1];
  assign reg_addr_bit0_o       = addr_r[0];
  assign card_read_strobe_n_o  = rd_n_r;
  assign card_write_strobe_n_o = wr_n_r;
  assign card_reset_n_o        = rst_n_r;
  assign card_data_o           = dout_r;
  assign card_data_oe_n_o      = oe_n_r;

  // ===========================================================================
  // Checks
  property p_sel_b_idle;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_r == ACP_IDLE) |-> ata_select_b_n_o;
  endproperty
  a_sel_b_idle: assert property (p_sel_b_idle) else $error("select b low in idle");
  property p_tf_select;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_r == ACP_IDLE && present && !reset_card_i && req_i && !req_alt_i)
      |=> !taskfile_select_n_o && ata_select_b_n_o;
  endproperty
  a_tf_select: assert property (p_tf_select) else $error("task-file select missed");
  property p_addr;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_r == ACP_IDLE && present && !reset_card_i && req_i)
      |=> {reg_addr_bit2_o, reg_addr_bit1_o, reg_addr_bit0_o} == $past(req_addr_i);
  endproperty
  a_addr: assert property (p_addr) else $error("register address not presented");
  property p_intr;
    @(posedge clk_i) disable iff (!nrst_i)
      (card_intr_req_i && present) |=> intr_pending_o;
  endproperty
  a_intr: assert property (p_intr) else $error("interrupt request not reported");
  property p_lane;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_r == ACP_SETUP && !data_r && !oe_n_r) |-> card_data_o[15:8] == 8'h00;
  endproperty
  a_lane: assert property (p_lane) else $error("task-file write drove high byte");
  property p_hold;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_r == ACP_WAIT && !card_io_ready_i && present)
      |=> (state_r == ACP_WAIT) && !(card_read_strobe_n_o && card_write_strobe_n_o);
  endproperty
  a_hold: assert property (p_hold) else $error("strobe ended early");
  property p_present;
    @(posedge clk_i) disable iff (!nrst_i)
      (card_present_a_n_i || card_present_b_n_i) |=> !card_inserted_o;
  endproperty
  a_present: assert property (p_present) else $error("false card presence");
  property p_reset_len;
    @(posedge clk_i) disable iff (!nrst_i)
      $fell(card_reset_n_o) && present |-> !card_reset_n_o [*8];
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("reset pulse too short");
  property p_strobes;
    @(posedge clk_i) disable iff (!nrst_i)
      !(card_read_strobe_n_o == 1'b0 && card_write_strobe_n_o == 1'b0);
  endproperty
  a_strobes: assert property (p_strobes) else $error("strobes overlap");
  property p_absent;
    @(posedge clk_i) disable iff (!nrst_i)
      !present |=> card_read_strobe_n_o && card_write_strobe_n_o && card_reset_n_o;
  endproperty
  a_absent: assert property (p_absent) else $error("outputs active with no card");
endmodule

//--- acp_card_model.sv
/*
  Behavioural card for the host port bench: register store, slow ready, pull-down bus.
  Assumes the host pins of one port and a wait length set by the bench.
*/
`timescale 1ns/1ps
module acp_card_model (
  input  wire logic        clk_i,
  input  wire logic        sel_a_n_i,
  input  wire logic        sel_b_n_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [7:0]  wait_i,
  output logic      [15:0] rdata_o,
  output logic             ready_o
);
  // ==========================================================================
  // Store and ready
  logic [15:0] mem [16];
  logic [7:0]  cnt_r;
  logic        act_r;
  logic        act;
  logic [3:0]  idx;
  assign idx = {sel_b_n_i, addr_i};
  assign act = !(sel_a_n_i && sel_b_n_i) && !(rd_n_i && wr_n_i);
  initial begin
    cnt_r = 8'h00;
    act_r = 1'b0;
  end
  // Ready drops for wait_i cycles after each strobe starts
  always @(posedge clk_i) begin
    act_r <= act;
    if (act && !act_r) cnt_r <= wait_i;
    else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
    if (act && !wr_n_i) mem[idx] <= wdata_i;
  end
  assign ready_o = (cnt_r == 8'h00);
  // Released bus reads as zero through the pull-downs
  assign rdata_o = (act && !rd_n_i) ? mem[idx] : 16'h0000;
endmodule

//--- tb.sv
/*
  Self-checking bench for the card host port with a behavioural card on its pins.
  Assumes the hand-over timing; detects and interrupt are driven here.
*/
`timescale 1ns/1ps
module tb;
  import acp_pkg::*;
  logic        clk_i, nrst_i, req, wr, dat, alt, rc, irq, rdy, pa_n, pb_n;
  logic        busy, done, pend, ins, sb_n, tf_n, rd_n, wr_n, crst_n, oe_n;
  logic [2:0]  ad;
  wire  [2:0]  addr;
  logic [7:0]  wait_c;
  logic [15:0] wd, rdat, dout, cdat, din, r;
  int          fail_count, n_checks, lo;
  assign din = oe_n ? cdat : dout;

  acp_host_port DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .req_write_i(wr), .req_data_i(dat),
    .req_alt_i(alt), .req_addr_i(ad), .req_wdata_i(wd), .reset_card_i(rc), .busy_o(busy),
    .done_o(done), .rdata_o(rdat), .intr_pending_o(pend), .card_inserted_o(ins),
    .ata_select_b_n_o(sb_n), .taskfile_select_n_o(tf_n), .reg_addr_bit2_o(addr[2]),
    .reg_addr_bit1_o(addr[1]), .reg_addr_bit0_o(addr[0]), .card_read_strobe_n_o(rd_n),
    .card_write_strobe_n_o(wr_n), .card_reset_n_o(crst_n), .card_data_i(din),
    .card_data_o(dout), .card_data_oe_n_o(oe_n), .card_intr_req_i(irq),
    .card_io_ready_i(rdy), .card_present_a_n_i(pa_n), .card_present_b_n_i(pb_n));
  acp_card_model card (
    .clk_i(clk_i), .sel_a_n_i(tf_n), .sel_b_n_i(sb_n), .addr_i(addr), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .wdata_i(dout), .wait_i(wait_c), .rdata_o(cdat), .ready_o(rdy));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One access; strobe must not end while the card holds ready low
  task automatic acc(input logic w, d, s, input logic [2:0] a, input logic [15:0] v);
    logic ok = 1'b1;
    logic hold = 1'b1;
    logic pw = 1'b0;
    logic sl;
    int n = 0;
    lo = 0;
    @(posedge clk_i);
    req <= 1'b1;
    wr <= w;
    dat <= d;
    alt <= s;
    ad <= a;
    wd <= v;
    @(posedge clk_i);
    req <= 1'b0;
    while (done !== 1'b1 && n < 500) begin
      @(negedge clk_i);
      n++;
      sl = w ? !wr_n : !rd_n;
      if (pw && !sl) hold = 1'b0;
      pw = sl && !rdy;
      if (sl) begin
        lo++;
        if ({tf_n, sb_n, addr, oe_n, w ? rd_n : wr_n} !== {s, !s, a, !w, 1'b1}) ok = 1'b0;
      end
    end
    r = rdat;
    chk("done", 16'h0001, {15'h0, done});
    chk("pins", 16'h0001, {15'h0, ok});
    chk("hold", 16'h0001, {15'h0, hold});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_idle;
    repeat (2) @(negedge clk_i);
    chk("idle", 16'h007e, {9'h0, sb_n, tf_n, rd_n, wr_n, crst_n, oe_n, busy});
    chk("inserted", 16'h0001, {15'h0, ins});
  endtask

  task automatic t_taskfile;
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 1'b0, 1'b0, 3'(i), {8'hff, 8'(8'h30 + i)});
      chk("tf_write", 16'(8'h30 + i), {8'h0, card.mem[8 + i][7:0]});
      acc(1'b0, 1'b0, 1'b0, 3'(i), 16'h0000);
      chk("tf_read", 16'(8'h30 + i), r);
      chk("strobe_len", 16'h0001, {15'h0, lo >= int'(STROBE_CYCLES)});
    end
  endtask

  // Card stalls 40 cycles: strobe low for the stall plus two edges
  task automatic t_data;
    wait_c <= 8'h28;
    for (int s = 0; s < 2; s++) begin
      acc(1'b1, 1'b1, 1'(s), 3'h0, 16'hbe00 + 16'(s));
      chk("wr_len", 16'h002a, 16'(lo));
      acc(1'b0, 1'b1, 1'(s), 3'h0, 16'h0000);
      chk("word", 16'hbe00 + 16'(s), r);
      chk("rd_len", 16'h002a, 16'(lo));
    end
    wait_c <= 8'h00;
  endtask

  task automatic t_intr;
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk_i);
      irq <= 1'(v);
      repeat (2) @(negedge clk_i);
      chk("intr", 16'(v), {15'h0, pend});
    end
  endtask

  task automatic t_card_reset;
    int n = 0;
    @(posedge clk_i);
    rc <= 1'b1;
    @(posedge clk_i);
    rc <= 1'b0;
    lo = 0;
    while (done !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
      if (crst_n === 1'b0) lo++;
    end
    chk("reset_len", 16'(RESET_CYCLES), 16'(lo));
  endtask

  // Any detect high means no card: request refused, pins idle
  task automatic t_detect;
    for (int m = 1; m < 4; m++) begin
      @(posedge clk_i);
      pa_n <= m[0];
      pb_n <= m[1];
      irq <= 1'b1;
      req <= 1'b1;
      @(posedge clk_i);
      req <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk("absent", 16'h0007, {10'h0, ins, pend, busy, rd_n, wr_n, crst_n});
      @(posedge clk_i);
      pa_n <= 1'b0;
      pb_n <= 1'b0;
      irq <= 1'b0;
      repeat (2) @(negedge clk_i);
    end
  endtask

  // ==========================================================================
  // Run
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    #100us;
    fail_count++;
    wrap_up();
  end

  initial begin
    fail_count = 0;
    n_checks = 0;
    nrst_i = 1'b0;
    {req, wr, dat, alt, rc, irq, pa_n, pb_n} = 8'h00;
    {ad, wd, wait_c} = 27'h0;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_idle();
    t_taskfile();
    t_data();
    t_intr();
    t_card_reset();
    t_detect();
    wrap_up();
  end
endmodule
